// ===== logic/asrcs_top.sv
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ns
module asrcs_top (
   input wire logic CLK_SYS_I,
   input wire logic SYS_RST_I,
   input wire logic HSEL_I,
   input wire logic [31:0] HADDR_I,
   input wire logic [1:0] HTRANS_I,
   input wire logic HWRITE_I,
   input wire logic [2:0] HSIZE_I,
   input wire logic [31:0] HWDATA_I,
   input wire logic HREADY_I,
   output logic [31:0] HRDATA_O,
   output logic HREADYOUT_O,
   output logic HRESP_O,
   input wire logic FS_IN_CLK_I,
   input wire logic FS_OUT_CLK_I,
   input wire logic SCLK_OUT_I,
   input wire logic SDATA_I,
   input wire logic [23:0] SAMPLE_I,
   input wire logic MUTE_I,
   input wire logic BYPASS_I,
   output logic MUTE_O,
   output logic SDATA_O,
   output logic [23:0] SAMPLE_O,
   output logic SAMPLE_VALID_O,
   output logic IRQ_O
);
   localparam int SW = asrcs_pkg::SMP_W;
   localparam int PW = asrcs_pkg::PH_W;
   localparam int GW = asrcs_pkg::GAIN_W;
   localparam int IW = asrcs_pkg::IRQ_W;

   // Pin synchronisers. The sample word is held stable across its frame,
   // so a plain two-flop stage per bit is safe once the frame edge is seen.
   logic [5:0] pin_s;
   logic [SW-1:0] smp_s;

   asrcs_sync #(
      .W(6)
   ) u_sync_pins (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .d_i({BYPASS_I, MUTE_I, SDATA_I, SCLK_OUT_I, FS_OUT_CLK_I, FS_IN_CLK_I}),
      .q_o(pin_s)
   );

   asrcs_sync #(
      .W(SW)
   ) u_sync_smp (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .d_i(SAMPLE_I),
      .q_o(smp_s)
   );

   wire logic fs_in_s = pin_s[0];
   wire logic fs_out_s = pin_s[1];
   wire logic sclk_s = pin_s[2];
   wire logic sdata_s = pin_s[3];
   wire logic mute_s = pin_s[4];
   wire logic bypass_s = pin_s[5];

   logic fs_in_q, fs_out_q, sclk_q;
   wire logic in_edge = fs_in_s && !fs_in_q;
   wire logic out_edge = fs_out_s && !fs_out_q;
   wire logic sclk_fall = !sclk_s && sclk_q;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         fs_in_q <= 1'b0;
         fs_out_q <= 1'b0;
         sclk_q <= 1'b0;
      end else begin
         fs_in_q <= fs_in_s;
         fs_out_q <= fs_out_s;
         sclk_q <= sclk_s;
      end
   end

   // Register slave. Zero wait states, always OKAY.
   logic wr_pend_q;
   logic [7:0] waddr_q;
   logic [31:0] hrdata_q;
   logic swmute_q;
   logic [IW-1:0] irq_stat_q, irq_mask_q;
   logic [GW-1:0] gain_q;

   asrcs_pkg::asrcs_servo_st_t sv_st;
   asrcs_pkg::asrcs_servo_ev_t sv_ev;
   logic [asrcs_pkg::CNT_W-1:0] per_in, per_out;

   function automatic logic wr_hit(input logic pend, input logic [7:0] a, input logic [7:0] off);
      wr_hit = pend && a == off;
   endfunction

   wire logic ahb_take = HSEL_I && HREADY_I && HTRANS_I == asrcs_pkg::HTRANS_NONSEQ;
   wire logic addr_ok = HADDR_I[31:8] == 24'h00_0000;
   wire logic wr_ctrl = wr_hit(wr_pend_q, waddr_q, asrcs_pkg::REG_CTRL);
   wire logic wr_istat = wr_hit(wr_pend_q, waddr_q, asrcs_pkg::REG_IRQ_STAT);
   wire logic wr_imask = wr_hit(wr_pend_q, waddr_q, asrcs_pkg::REG_IRQ_MASK);
   wire logic resettle = wr_ctrl && HWDATA_I[asrcs_pkg::CTRL_RESETTLE];
   wire logic [IW-1:0] irq_clr = wr_istat ? HWDATA_I[IW-1:0] : '0;
   wire logic [IW-1:0] irq_set = sv_ev;
   wire logic [7:0] raddr = HADDR_I[7:0];

   wire logic [31:0] status_w = (32'(gain_q) << asrcs_pkg::ST_GAIN)
                              | (32'(bypass_s) << asrcs_pkg::ST_BYP)
                              | (32'(MUTE_O) << asrcs_pkg::ST_MUTE)
                              | (32'(sv_st.locked) << asrcs_pkg::ST_LOCK)
                              | (32'(sv_st.mode) << asrcs_pkg::ST_MODE);
   wire logic [31:0] ctrl_w = 32'(swmute_q) << asrcs_pkg::CTRL_SWMUTE;
   wire logic [31:0] rd_word =
      !addr_ok ? 32'h0000_0000 :
      raddr == asrcs_pkg::REG_CTRL ? ctrl_w :
      raddr == asrcs_pkg::REG_STATUS ? status_w :
      raddr == asrcs_pkg::REG_IRQ_STAT ? 32'(irq_stat_q) :
      raddr == asrcs_pkg::REG_IRQ_MASK ? 32'(irq_mask_q) :
      raddr == asrcs_pkg::REG_PERIOD ? {per_out, per_in} :
      raddr == asrcs_pkg::REG_PHASE ? 32'(sv_st.phase) : 32'h0000_0000;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         wr_pend_q <= 1'b0;
         waddr_q <= '0;
         hrdata_q <= '0;
      end else begin
         wr_pend_q <= ahb_take && HWRITE_I && addr_ok;
         if (ahb_take) waddr_q <= raddr;
         if (ahb_take && !HWRITE_I) hrdata_q <= rd_word;
      end
   end

   // Set wins over a same-cycle write-one-to-clear, so no event is lost.
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         swmute_q <= asrcs_pkg::CTRL_SWMUTE_RST;
         irq_stat_q <= '0;
         irq_mask_q <= asrcs_pkg::IRQ_MASK_RST;
      end else begin
         if (wr_ctrl) swmute_q <= HWDATA_I[asrcs_pkg::CTRL_SWMUTE];
         irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
         if (wr_imask) irq_mask_q <= HWDATA_I[IW-1:0];
      end
   end

   assign HRDATA_O = hrdata_q;
   assign HREADYOUT_O = 1'b1;
   assign HRESP_O = 1'b0;
   assign IRQ_O = |(irq_stat_q & irq_mask_q);

   asrcs_servo u_servo (
      .clk_i(CLK_SYS_I),
      .rst_i(SYS_RST_I),
      .in_edge_i(in_edge),
      .out_edge_i(out_edge),
      .resettle_i(resettle),
      .st_o(sv_st),
      .ev_o(sv_ev),
      .per_in_o(per_in),
      .per_out_o(per_out)
   );

   assign MUTE_O = sv_st.mode == asrcs_pkg::SV_FAST;

   // Input history. The output lags one input frame so both neighbours
   // of the chosen phase point are always present.
   logic signed [SW-1:0] x0_q, x1_q, interp_q;
   logic v1_q;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         x0_q <= '0;
         x1_q <= '0;
      end else if (in_edge) begin
         x0_q <= x1_q;
         x1_q <= smp_s;
      end
   end

   // The phase picks one of 2^20 points between neighbours; the linear
   // kernel is the low-pass that removes the zero-stuffing images. A longer
   // polyphase kernel would cut images further at the cost of memory.
   wire logic signed [SW:0] diff = {x1_q[SW-1], x1_q} - {x0_q[SW-1], x0_q};
   wire logic signed [SW+PW+1:0] prod = diff * $signed({1'b0, sv_st.phase});
   wire logic [SW:0] sum = {x0_q[SW-1], x0_q} + prod[SW+PW:PW];
   wire logic signed [SW-1:0] interp = sum[SW-1:0];
   wire logic signed [SW-1:0] lo = (x0_q < x1_q) ? x0_q : x1_q;
   wire logic signed [SW-1:0] hi = (x0_q < x1_q) ? x1_q : x0_q;
   wire logic signed [SW+GW:0] gprod = interp_q * $signed({1'b0, gain_q});
   wire logic mute_eff = mute_s || swmute_q;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         interp_q <= '0;
         v1_q <= 1'b0;
      end else begin
         v1_q <= out_edge;
         if (out_edge) interp_q <= bypass_s ? x1_q : interp;
      end
   end

   // Gain moves one step per output frame, so mute and unmute are gradual.
   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         gain_q <= asrcs_pkg::GAIN_RST;
      end else if (out_edge) begin
         if (mute_eff && gain_q != '0) gain_q <= gain_q - asrcs_pkg::GAIN_STEP;
         else if (!mute_eff && gain_q != asrcs_pkg::GAIN_FULL) gain_q <= gain_q + asrcs_pkg::GAIN_STEP;
      end
   end

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         SAMPLE_O <= '0;
         SAMPLE_VALID_O <= 1'b0;
      end else begin
         SAMPLE_VALID_O <= v1_q;
         if (v1_q) SAMPLE_O <= bypass_s ? interp_q : gprod[SW-1+asrcs_pkg::GAIN_SHIFT:asrcs_pkg::GAIN_SHIFT];
      end
   end

   // Serial output: the word is loaded at the output frame edge and shifted
   // out MSB first at falling bit-clock edges. It carries the previous frame.
   logic [SW-1:0] sr_q;

   always_ff @(posedge CLK_SYS_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         sr_q <= '0;
         SDATA_O <= 1'b0;
      end else begin
         if (out_edge) sr_q <= SAMPLE_O;
         else if (sclk_fall) sr_q <= {sr_q[SW-2:0], 1'b0};
         SDATA_O <= bypass_s ? sdata_s : sr_q[SW-1];
      end
   end

   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (SYS_RST_I);

   sequence s_byp_held;
      bypass_s ##1 bypass_s;
   endsequence
   sequence s_out_pipe;
      ##2 SAMPLE_VALID_O;
   endsequence

   property p_mute_fast;
      sv_st.mode == asrcs_pkg::SV_FAST |-> MUTE_O;
   endproperty
   a_mute_fast: assert property (p_mute_fast) else $error("mute request low in fast mode");

   property p_mute_slow;
      $fell(MUTE_O) |-> $past(sv_ev.enter_slow) && sv_st.mode == asrcs_pkg::SV_SLOW;
   endproperty
   a_mute_slow: assert property (p_mute_slow) else $error("mute request dropped without slow entry");

   property p_gain_down;
      out_edge && mute_eff && gain_q != '0 |=> gain_q == $past(gain_q) - asrcs_pkg::GAIN_STEP;
   endproperty
   a_gain_down: assert property (p_gain_down) else $error("mute ramp step wrong");

   property p_gain_up;
      out_edge && !mute_eff && gain_q != asrcs_pkg::GAIN_FULL |=> gain_q == $past(gain_q) + asrcs_pkg::GAIN_STEP;
   endproperty
   a_gain_up: assert property (p_gain_up) else $error("unmute ramp step wrong");

   property p_gain_hold;
      !out_edge |=> $stable(gain_q);
   endproperty
   a_gain_hold: assert property (p_gain_hold) else $error("gain moved between frames");

   property p_bypass_sdata;
      s_byp_held |-> SDATA_O == $past(sdata_s);
   endproperty
   a_bypass_sdata: assert property (p_bypass_sdata) else $error("bypass serial data altered");

   property p_out_pipe;
      out_edge |-> s_out_pipe;
   endproperty
   a_out_pipe: assert property (p_out_pipe) else $error("output sample not produced in two cycles");

   property p_interp_bound;
      out_edge && !bypass_s && $stable(x1_q) |=> interp_q >= $past(lo) && interp_q <= $past(hi);
   endproperty
   a_interp_bound: assert property (p_interp_bound) else $error("interpolated point outside neighbours");
endmodule // asrcs_top

// ===== common/asrcs_pkg.sv
// Behaviour
// - Reset release or any input/output rate change puts the servo into fast settling.
// - Adequate fast settling moves the servo to slow mode, settling toward 5 ps.
// - Servo measures input-to-output sample offset finely and picks the filter phase.
// - Servo rejects sample and master clock jitter, rejection starting below 1 Hz.
// - Settle mute request output is high throughout fast settling.
// - Soft mute ramps audio gradually to silence, and release ramps back to full.
// - Bypass forwards serial input straight to serial output, no conversion or dither.
// - Resampler acts as a 2^20 interpolator, each output taking the nearest point.
// - Interpolated input is low-pass filtered to suppress images before output resampling.
package asrcs_pkg;
   localparam int INTERP_LOG2 = 20;
   localparam int PH_W = INTERP_LOG2;
   localparam int CNT_W = 16;
   localparam int SMP_W = 24;
   localparam int GAIN_W = 9;
   localparam int GAIN_SHIFT = 8;
   // A long slow-mode shift puts the loop corner well below the audio band.
   localparam int FAST_SHIFT = 2;
   localparam int SLOW_SHIFT = 10;
   // The rate term integrates more gently than the phase term so the loop stays damped.
   localparam int RATE_SHIFT = 4;
   localparam logic [PH_W-1:0] FAST_EXIT_LSB = 20'h0_4000;
   // One phase step is about 5 ps at the highest input rate.
   localparam logic [PH_W-1:0] LOCK_TOL_LSB = 20'h0_0001;
   localparam logic [3:0] FAST_GOOD_CNT = 4'h8;
   localparam logic [CNT_W-1:0] RATE_TOL = 16'h0004;
   localparam logic [GAIN_W-1:0] GAIN_FULL = 9'h100;
   localparam logic [GAIN_W-1:0] GAIN_STEP = 9'h001;
   localparam logic [GAIN_W-1:0] GAIN_RST = 9'h000;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IRQ_STAT = 8'h08;
   localparam logic [7:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [7:0] REG_PERIOD = 8'h10;
   localparam logic [7:0] REG_PHASE = 8'h14;
   localparam int CTRL_RESETTLE = 0;
   localparam int CTRL_SWMUTE = 1;
   localparam int ST_MODE = 0;
   localparam int ST_LOCK = 1;
   localparam int ST_MUTE = 2;
   localparam int ST_BYP = 3;
   localparam int ST_GAIN = 8;
   localparam int IRQ_W = 4;
   localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
   localparam logic CTRL_SWMUTE_RST = 1'b0;
   typedef enum logic [0:0] {SV_FAST = 1'b0, SV_SLOW = 1'b1} asrcs_mode_t;
   typedef struct packed {
      asrcs_mode_t mode;
      logic locked;
      logic [PH_W-1:0] phase;
   } asrcs_servo_st_t;
   // Bit order matches the interrupt status register.
   typedef struct packed {
      logic rate_chg;
      logic lock_rise;
      logic enter_slow;
      logic enter_fast;
   } asrcs_servo_ev_t;
endpackage

// ===== logic/asrcs_sync.sv
`timescale 1ns/1ns
module asrcs_sync #(
   parameter int W = 1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta_q <= '0;
         q_o <= '0;
      end else begin
         meta_q <= d_i;
         q_o <= meta_q;
      end
   end
endmodule // asrcs_sync

// ===== logic/asrcs_servo.sv
`timescale 1ns/1ns
module asrcs_servo (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic in_edge_i,
   input wire logic out_edge_i,
   input wire logic resettle_i,
   output asrcs_pkg::asrcs_servo_st_t st_o,
   output asrcs_pkg::asrcs_servo_ev_t ev_o,
   output logic [asrcs_pkg::CNT_W-1:0] per_in_o,
   output logic [asrcs_pkg::CNT_W-1:0] per_out_o
);
   localparam int CW = asrcs_pkg::CNT_W;
   localparam int PW = asrcs_pkg::PH_W;
   logic [CW-1:0] cnt_in_q, cnt_out_q;
   logic [CW:0] rem_q;
   logic [PW-1:0] quo_q, est_q;
   // A rate term lets the loop follow a steady frame ratio other than one without a standing phase error.
   logic signed [PW-1:0] vel_q;
   logic [4:0] div_cnt_q;
   logic busy_q, done_q, locked_q;
   logic [3:0] good_q;
   asrcs_pkg::asrcs_mode_t mode_q;

   function automatic logic far(input logic [CW-1:0] a, input logic [CW-1:0] b);
      far = ((a > b) ? a - b : b - a) > asrcs_pkg::RATE_TOL;
   endfunction

   wire logic [CW-1:0] in_len = cnt_in_q + 16'h0001;
   wire logic [CW-1:0] out_len = cnt_out_q + 16'h0001;
   wire logic rate_chg = (in_edge_i && far(in_len, per_in_o)) || (out_edge_i && far(out_len, per_out_o));
   wire logic go_fast = rate_chg || resettle_i;
   wire logic start = out_edge_i && !busy_q && (per_in_o != '0);
   wire logic [CW:0] rem2 = {rem_q[CW-1:0], 1'b0};
   wire logic ge = rem2 >= {1'b0, per_in_o};
   wire logic signed [PW-1:0] err = $signed(quo_q - est_q);
   wire logic [PW-1:0] mag = err[PW-1] ? PW'(-err) : PW'(err);
   wire logic signed [PW-1:0] corr = (mode_q == asrcs_pkg::SV_FAST) ? err >>> asrcs_pkg::FAST_SHIFT
                                                                    : err >>> asrcs_pkg::SLOW_SHIFT;
   wire logic good = mag < asrcs_pkg::FAST_EXIT_LSB;
   wire logic go_slow = done_q && !go_fast && mode_q == asrcs_pkg::SV_FAST && good
                        && good_q == asrcs_pkg::FAST_GOOD_CNT - 4'h1;
   wire logic lock_nx = done_q && mode_q == asrcs_pkg::SV_SLOW && !go_fast && mag <= asrcs_pkg::LOCK_TOL_LSB;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_in_q <= '0;
         cnt_out_q <= '0;
         per_in_o <= '0;
         per_out_o <= '0;
      end else begin
         cnt_in_q <= in_edge_i ? '0 : in_len;
         cnt_out_q <= out_edge_i ? '0 : out_len;
         if (in_edge_i) per_in_o <= in_len;
         if (out_edge_i) per_out_o <= out_len;
      end
   end

   // Offset since the last input frame divided by the input period gives the 2^20 phase.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rem_q <= '0;
         quo_q <= '0;
         div_cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= busy_q && div_cnt_q == 5'(PW - 1);
         if (start) begin
            rem_q <= {1'b0, cnt_in_q};
            quo_q <= '0;
            div_cnt_q <= '0;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            rem_q <= ge ? rem2 - {1'b0, per_in_o} : rem2;
            quo_q <= {quo_q[PW-2:0], ge};
            div_cnt_q <= div_cnt_q + 5'h01;
            busy_q <= div_cnt_q != 5'(PW - 1);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         mode_q <= asrcs_pkg::SV_FAST;
         est_q <= '0;
         vel_q <= '0;
         good_q <= '0;
         locked_q <= 1'b0;
      end else begin
         if (done_q) est_q <= est_q + PW'(vel_q) + PW'(corr);
         // Fast mode relearns the frame ratio from zero; slow mode only trims the phase.
         if (go_fast) vel_q <= '0;
         else if (done_q && mode_q == asrcs_pkg::SV_FAST) vel_q <= vel_q + (err >>> asrcs_pkg::RATE_SHIFT);
         if (go_fast) mode_q <= asrcs_pkg::SV_FAST;
         else if (go_slow) mode_q <= asrcs_pkg::SV_SLOW;
         if (go_fast) good_q <= '0;
         else if (done_q) good_q <= good ? good_q + 4'h1 : '0;
         if (go_fast) locked_q <= 1'b0;
         else if (done_q) locked_q <= lock_nx;
      end
   end

   assign st_o = '{mode: mode_q, locked: locked_q, phase: est_q};
   assign ev_o = '{rate_chg: rate_chg, lock_rise: lock_nx && !locked_q, enter_slow: go_slow,
                   enter_fast: go_fast && mode_q == asrcs_pkg::SV_SLOW};

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_div_start;
      start;
   endsequence
   property p_rate_fast;
      rate_chg |=> mode_q == asrcs_pkg::SV_FAST;
   endproperty
   a_rate_fast: assert property (p_rate_fast) else $error("rate change did not force fast mode");
   property p_slow_entry;
      $rose(mode_q == asrcs_pkg::SV_SLOW) |-> $past(good_q) == asrcs_pkg::FAST_GOOD_CNT - 4'h1 && $past(done_q);
   endproperty
   a_slow_entry: assert property (p_slow_entry) else $error("slow mode entered without settling");
   property p_div_len;
      s_div_start |-> ##21 done_q;
   endproperty
   a_div_len: assert property (p_div_len) else $error("phase measurement latency wrong");
   property p_slow_step;
      mode_q == asrcs_pkg::SV_SLOW && done_q |=> PW'(est_q - $past(est_q) - $past(vel_q) + 20'h0_0200) <= 20'h0_0400;
   endproperty
   a_slow_step: assert property (p_slow_step) else $error("slow mode phase step too large");
   property p_slow_rate;
      mode_q == asrcs_pkg::SV_SLOW && !go_fast |=> $stable(vel_q);
   endproperty
   a_slow_rate: assert property (p_slow_rate) else $error("rate term moved in slow mode");
endmodule // asrcs_servo

// ===== tb/asrcs_partner.sv
`timescale 1ns/1ns
module asrcs_partner (
   input wire logic clk_i,
   input wire logic [15:0] in_half_i,
   input wire logic [15:0] out_half_i,
   output logic fs_in_o,
   output logic fs_out_o,
   output logic sclk_o,
   output logic sdata_o,
   output logic [23:0] sample_o
);
   logic [15:0] in_cnt = 16'h0000;
   logic [15:0] out_cnt = 16'h0000;
   logic [7:0] bit_cnt = 8'h00;
   initial begin
      fs_in_o = 1'b0;
      fs_out_o = 1'b0;
      sclk_o = 1'b1;
      sdata_o = 1'b0;
      sample_o = 24'h00_0000;
   end
   // The sample changes on the falling frame edge, so it is stable well around each rising edge.
   always @(posedge clk_i) begin
      in_cnt <= (in_cnt >= in_half_i - 16'h0001) ? 16'h0000 : in_cnt + 16'h0001;
      out_cnt <= (out_cnt >= out_half_i - 16'h0001) ? 16'h0000 : out_cnt + 16'h0001;
      if (in_cnt >= in_half_i - 16'h0001) begin
         fs_in_o <= ~fs_in_o;
         if (fs_in_o) begin
            sample_o <= sample_o + 24'h01_2345;
         end
      end
      if (out_cnt >= out_half_i - 16'h0001) begin
         fs_out_o <= ~fs_out_o;
      end
      bit_cnt <= bit_cnt + 8'h01;
      sdata_o <= bit_cnt[3] ^ bit_cnt[5];
   end
   // The bit clock runs only inside the output frame and rests high between frames.
   always begin
      #16;
      sclk_o = fs_out_o ? ~sclk_o : 1'b1;
   end
endmodule // asrcs_partner

// ===== tb/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic CLK_SYS_I = 1'b0;
   logic SYS_RST_I = 1'b1;
   logic HSEL_I = 1'b0;
   logic [31:0] HADDR_I = 32'h0000_0000;
   logic [1:0] HTRANS_I = 2'h0;
   logic HWRITE_I = 1'b0;
   logic [31:0] HWDATA_I = 32'h0000_0000;
   logic MUTE_I = 1'b0;
   logic BYPASS_I = 1'b0;
   logic [15:0] in_half = 16'h0050;
   logic [15:0] out_half = 16'h004B;
   wire logic [31:0] HRDATA_O;
   wire logic HREADYOUT_O, HRESP_O, FS_IN_CLK_I, FS_OUT_CLK_I, SCLK_OUT_I, SDATA_I;
   wire logic MUTE_O, SDATA_O, SAMPLE_VALID_O, IRQ_O;
   wire logic [23:0] SAMPLE_I, SAMPLE_O;
   int n_fail = 0;
   int comparisons = 0;
   always #2 CLK_SYS_I = ~CLK_SYS_I;
   asrcs_partner asrcs_partner_inst (.clk_i(CLK_SYS_I), .in_half_i(in_half), .out_half_i(out_half),
      .fs_in_o(FS_IN_CLK_I), .fs_out_o(FS_OUT_CLK_I), .sclk_o(SCLK_OUT_I), .sdata_o(SDATA_I),
      .sample_o(SAMPLE_I));
   asrcs_top asrcs_top_inst (.CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .HSEL_I(HSEL_I),
      .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I), .HSIZE_I(3'h2), .HWDATA_I(HWDATA_I),
      .HREADY_I(HREADYOUT_O), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
      .FS_IN_CLK_I(FS_IN_CLK_I), .FS_OUT_CLK_I(FS_OUT_CLK_I), .SCLK_OUT_I(SCLK_OUT_I),
      .SDATA_I(SDATA_I), .SAMPLE_I(SAMPLE_I), .MUTE_I(MUTE_I), .BYPASS_I(BYPASS_I), .MUTE_O(MUTE_O),
      .SDATA_O(SDATA_O), .SAMPLE_O(SAMPLE_O), .SAMPLE_VALID_O(SAMPLE_VALID_O), .IRQ_O(IRQ_O));
   task automatic final_report();
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask
   // Zero wait states are expected, but the handshake is still honoured in case of a stall.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
      int n;
      n = 0;
      HSEL_I <= 1'b1;
      HTRANS_I <= asrcs_pkg::HTRANS_NONSEQ;
      HADDR_I <= {24'h00_0000, a};
      HWRITE_I <= w;
      do begin
         @(posedge CLK_SYS_I);
         n++;
      end while (HREADYOUT_O !== 1'b1 && n < 64);
      HTRANS_I <= 2'h0;
      HWDATA_I <= wd;
      do begin
         @(posedge CLK_SYS_I);
         n++;
      end while (HREADYOUT_O !== 1'b1 && n < 64);
      r = HRDATA_O;
      if (n >= 64) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(1'b0, a, 32'h0000_0000, r);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task automatic wait_mode(input logic m);
      logic [31:0] r;
      int k;
      k = 0;
      do begin
         repeat (16) @(posedge CLK_SYS_I);
         rd(asrcs_pkg::REG_STATUS, r);
         k++;
      end while (r[asrcs_pkg::ST_MODE] !== m && k < 1000);
      if (k >= 1000) begin
         n_fail++;
         final_report();
      end
   endtask
   task automatic t_reset();
      logic [31:0] r;
      rd(asrcs_pkg::REG_STATUS, r);
      chk32(r & 32'h0000_0007, 32'h0000_0004);
      chk1(MUTE_O, 1'b1);
      chk1(IRQ_O, 1'b0);
      chk1(HRESP_O, 1'b0);
      rd(asrcs_pkg::REG_IRQ_MASK, r);
      chk32(r, 32'h0000_0000);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, r);
      chk32(r, 32'h0000_0000);
   endtask
   task automatic t_settle();
      logic [31:0] r;
      wait_mode(1'b1);
      repeat (4) @(posedge CLK_SYS_I);
      chk1(MUTE_O, 1'b0);
      rd(asrcs_pkg::REG_PERIOD, r);
      chk32(r, {out_half, in_half} << 1);
      rd(asrcs_pkg::REG_IRQ_STAT, r);
      chk1(r[1], 1'b1);
      chk1(IRQ_O, 1'b0);
      wr(asrcs_pkg::REG_IRQ_MASK, 32'h0000_0002);
      repeat (2) @(posedge CLK_SYS_I);
      chk1(IRQ_O, 1'b1);
      wr(asrcs_pkg::REG_IRQ_STAT, 32'h0000_0002);
      repeat (2) @(posedge CLK_SYS_I);
      chk1(IRQ_O, 1'b0);
   endtask
   task automatic t_resettle();
      logic [31:0] r;
      wr(asrcs_pkg::REG_CTRL, 32'h0000_0001);
      repeat (4) @(posedge CLK_SYS_I);
      chk1(MUTE_O, 1'b1);
      rd(asrcs_pkg::REG_IRQ_STAT, r);
      chk1(r[0], 1'b1);
      wait_mode(1'b1);
   endtask
   task automatic t_rate();
      logic [31:0] r;
      wr(asrcs_pkg::REG_IRQ_STAT, 32'h0000_000F);
      out_half <= 16'h005A;
      wait_mode(1'b0);
      chk1(MUTE_O, 1'b1);
      rd(asrcs_pkg::REG_IRQ_STAT, r);
      chk1(r[3], 1'b1);
      chk1(r[0], 1'b1);
      wait_mode(1'b1);
   endtask
   task automatic t_mute();
      logic [31:0] r;
      logic [8:0] g1, g2, g3;
      rd(asrcs_pkg::REG_STATUS, r);
      g1 = r[16:8];
      MUTE_I <= 1'b1;
      repeat (40 * out_half) @(posedge CLK_SYS_I);
      rd(asrcs_pkg::REG_STATUS, r);
      g2 = r[16:8];
      chk1(g2 < g1 && g1 - g2 <= 9'h015, 1'b1);
      MUTE_I <= 1'b0;
      repeat (40 * out_half) @(posedge CLK_SYS_I);
      rd(asrcs_pkg::REG_STATUS, r);
      g3 = r[16:8];
      chk1(g3 > g2 && g3 - g2 <= 9'h015, 1'b1);
   endtask
   task automatic t_bypass();
      logic [31:0] r;
      logic [5:0] hist;
      logic [23:0] last, prev;
      logic fs_prev;
      int rises, seen;
      out_half <= in_half;
      BYPASS_I <= 1'b1;
      repeat (8) @(posedge CLK_SYS_I);
      rd(asrcs_pkg::REG_STATUS, r);
      chk1(r[asrcs_pkg::ST_BYP], 1'b1);
      hist = 6'h15;
      repeat (200) begin
         @(posedge CLK_SYS_I);
         hist = {hist[4:0], SDATA_I};
         if (hist == 6'h00 || hist == 6'h3F) begin
            chk1(SDATA_O, hist[0]);
         end
      end
      // The strobe may come just before or just after the newest input frame is taken in.
      last = 24'h00_0000;
      prev = 24'h00_0000;
      fs_prev = 1'b1;
      rises = 0;
      seen = 0;
      repeat (800) begin
         @(posedge CLK_SYS_I);
         if (SAMPLE_VALID_O === 1'b1 && rises >= 2) begin
            seen++;
            chk1(SAMPLE_O === last || SAMPLE_O === prev, 1'b1);
         end
         if (FS_IN_CLK_I === 1'b1 && fs_prev === 1'b0) begin
            prev = last;
            last = SAMPLE_I;
            rises++;
         end
         fs_prev = FS_IN_CLK_I;
      end
      chk1(seen >= 2, 1'b1);
      BYPASS_I <= 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge CLK_SYS_I);
      SYS_RST_I <= 1'b0;
      t_reset();
      t_settle();
      t_resettle();
      t_rate();
      t_mute();
      t_bypass();
      final_report();
   end
endmodule // testbench
